// ### logic/clc_regs.svh
// constants for the configuration lock control block: offsets, fields, resets
// assumes a 32-bit AHB-Lite register bus, word aligned registers
`ifndef CLC_REGS_SVH
`define CLC_REGS_SVH

// register offsets (byte addresses)
`define CLC_CFG_OFF        12'h000
`define CLC_UNLOCK_OFF     12'h004
`define CLC_REMAP_OFF      12'h010
`define CLC_MODDIS_OFF     12'h020

// configuration_control field positions
`define CLC_POS_REMAP_LOCK 13
`define CLC_POS_MODDIS_LOCK 12
`define CLC_POS_DBG_EN     3
`define CLC_POS_TWO_WIRE   0

// reset values and masks
`define CLC_CFG_RESET      32'h0000_0001
`define CLC_CFG_MASK       32'h0000_3009
`define CLC_LOCK_MASK      32'h0000_3000

// unlock key pair, written in turn to the unlock register
`define CLC_KEY1           32'hAA99_6655
`define CLC_KEY2           32'h5566_99AA

`endif

// ### logic/clc_pkg.sv
// types for the configuration lock control block
// assumes clc_regs.svh is included by the user of the constants
package clc_pkg;
    // unlock sequence progress
    typedef enum logic [1:0] {
        clc_locked,
        clc_key1_seen,
        clc_unlocked
    } clc_unlock_type;

    // captured ahb address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } clc_aphase_type;
endpackage

// ### logic/clc_config_lock.sv
// configuration control register with lock bits, unlock sequence and
// protected pin remap / module disable register banks, on AHB-Lite
// assumes a single master issuing single word transfers; hready tied to
// hreadyout; cfg_debug_port_enable is the nonvolatile configuration bit
// and holds still from reset release onward; the slave never waits and
// answers every transfer okay, so the bus sees one cycle per phase
`timescale 1ns/100ps
`include "clc_regs.svh"

module clc_config_lock #(
    parameter int NREMAP  = 4,
    parameter int NMODDIS = 2
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // configuration word strap
    input  wire logic        cfg_debug_port_enable,
    // control outputs
    output logic             debug_port_enable,
    output logic             two_wire_output_use,
    output logic             pin_remap_lock,
    output logic             module_disable_lock,
    output logic             unlocked
);

    // ========================================
    // state and storage
    clc_pkg::clc_aphase_type aph;           // address phase held into the data phase
    logic [31:0]             remap_regs  [NREMAP];
    logic [31:0]             moddis_regs [NMODDIS];
    logic                    strap_done;    // configuration bit copied once
    clc_pkg::clc_unlock_type unlock_state;

    // next values, shared by the registers and the read path so that a read
    // issued right behind a write already returns the written contents
    clc_pkg::clc_unlock_type next_unlock_state;
    logic                    next_pin_remap_lock;
    logic                    next_module_disable_lock;
    logic                    next_debug_port_enable;
    logic                    next_two_wire_output_use;
    logic [31:0]             next_hrdata;

    // data phase write decode
    logic                    wr;
    logic                    wr_cfg;
    logic                    wr_unlock;
    int                      wr_remap_idx;
    int                      wr_moddis_idx;
    logic                    remap_we;
    logic                    moddis_we;

    // address phase read decode
    int                      rd_remap_idx;
    int                      rd_moddis_idx;

    // index of a bank word, or -1 when outside the bank
    // limitation: base + 4*n must stay inside the 12-bit address space
    function automatic int bank_index(input logic [11:0] a, input logic [11:0] base,
                                      input int n);
        int i;
        i = -1;
        if (a >= base && a < base + 12'(n * 4) && a[1:0] == 2'b00) begin
            i = int'((a - base) >> 2);
        end
        return i;
    endfunction

    // ========================================
    // ahb-lite address phase capture
    // only 32-bit writes take effect; other sizes are taken, their writes ignored, their reads still answered
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aph <= '0;
        end else if (hready) begin
            aph.valid <= hsel && htrans[1] && (hsize == 3'b010);
            aph.write <= hwrite;
            aph.addr  <= haddr;
        end
    end

    // zero wait states, always okay
    // a plain register bank has nothing to wait for, so ready never drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ========================================
    // write decode; hwdata stands during the data phase that follows aph
    assign wr        = aph.valid && aph.write;
    assign wr_cfg    = wr && (aph.addr == `CLC_CFG_OFF);
    assign wr_unlock = wr && (aph.addr == `CLC_UNLOCK_OFF);

    // bank slots for the write in flight, -1 when outside a bank
    assign wr_remap_idx  = bank_index(aph.addr, `CLC_REMAP_OFF, NREMAP);
    assign wr_moddis_idx = bank_index(aph.addr, `CLC_MODDIS_OFF, NMODDIS);

    assign remap_we  = wr && (wr_remap_idx >= 0) && !pin_remap_lock;
    // module disable writes refused while locked
    assign moddis_we = wr && (wr_moddis_idx >= 0) && !module_disable_lock;

    // read side decode is taken from the live address phase
    assign rd_remap_idx  = bank_index(haddr, `CLC_REMAP_OFF, NREMAP);
    assign rd_moddis_idx = bank_index(haddr, `CLC_MODDIS_OFF, NMODDIS);

    // ========================================
    // unlock sequence: key1 then key2 opens; a zero written to the unlock
    // register closes again, any other value leaves it open
    // unlock sequence gate
    always_comb begin
        next_unlock_state = unlock_state;
        if (wr_unlock) begin
            case (unlock_state)
                clc_pkg::clc_locked: begin
                    if (hwdata == `CLC_KEY1) begin
                        next_unlock_state = clc_pkg::clc_key1_seen;
                    end
                end
                clc_pkg::clc_key1_seen: begin
                    // a wrong second key drops back, so keys must come in pairs
                    if (hwdata == `CLC_KEY2) begin
                        next_unlock_state = clc_pkg::clc_unlocked;
                    end else begin
                        next_unlock_state = clc_pkg::clc_locked;
                    end
                end
                clc_pkg::clc_unlocked: begin
                    if (hwdata == 32'h0000_0000) begin
                        next_unlock_state = clc_pkg::clc_locked;
                    end
                end
                default: begin
                    next_unlock_state = clc_pkg::clc_locked;
                end
            endcase
        end
    end

    // unlock state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unlock_state <= clc_pkg::clc_locked;
        end else begin
            unlock_state <= next_unlock_state;
        end
    end

    // unlocked pin follows the state one cycle later
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            unlocked <= 1'b0;
        end else begin
            unlocked <= (unlock_state == clc_pkg::clc_unlocked);
        end
    end

    // ========================================
    // configuration_control fields
    // lock bits move only when unlocked
    always_comb begin
        next_pin_remap_lock      = pin_remap_lock;
        next_module_disable_lock = module_disable_lock;
        if (wr_cfg && unlock_state == clc_pkg::clc_unlocked) begin
            next_pin_remap_lock      = hwdata[`CLC_POS_REMAP_LOCK];
            next_module_disable_lock = hwdata[`CLC_POS_MODDIS_LOCK];
        end
    end

    // configuration bit copied at the first edge after reset
    // the copy cannot sit in the reset branch, which takes constants only;
    // a write in that very cycle loses to the copy
    always_comb begin
        next_debug_port_enable = debug_port_enable;
        if (!strap_done) begin
            next_debug_port_enable = cfg_debug_port_enable;
        end else if (wr_cfg) begin
            next_debug_port_enable = hwdata[`CLC_POS_DBG_EN];
        end
    end

    // two-wire tdo use, writable without unlocking
    always_comb begin
        next_two_wire_output_use = two_wire_output_use;
        if (wr_cfg) begin
            next_two_wire_output_use = hwdata[`CLC_POS_TWO_WIRE];
        end
    end

    // lock bits, reset open
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_remap_lock      <= 1'b0;
            module_disable_lock <= 1'b0;
        end else begin
            pin_remap_lock      <= next_pin_remap_lock;
            module_disable_lock <= next_module_disable_lock;
        end
    end

    // debug port enable and its one-shot copy flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_done        <= 1'b0;
            debug_port_enable <= 1'b0;
        end else begin
            strap_done        <= 1'b1;
            debug_port_enable <= next_debug_port_enable;
        end
    end

    // two-wire tdo use resets to one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            two_wire_output_use <= 1'b1;
        end else begin
            two_wire_output_use <= next_two_wire_output_use;
        end
    end

    // ========================================
    // protected banks
    // remap bank, written only while its lock is clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < NREMAP; k++) begin
                remap_regs[k] <= 32'h0000_0000;
            end
        end else if (remap_we) begin
            remap_regs[wr_remap_idx] <= hwdata;
        end
    end

    // module disable bank, written only while its lock is clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int k = 0; k < NMODDIS; k++) begin
                moddis_regs[k] <= 32'h0000_0000;
            end
        end else if (moddis_we) begin
            moddis_regs[wr_moddis_idx] <= hwdata;
        end
    end

    // ========================================
    // read data, registered at the address phase so it stands in the data phase;
    // built from next values so a write finishing at that same edge is seen
    always_comb begin
        logic [31:0] cfg;
        logic [31:0] word;
        cfg  = 32'h0000_0000;
        word = 32'h0000_0000;
        cfg[`CLC_POS_REMAP_LOCK]  = next_pin_remap_lock;
        cfg[`CLC_POS_MODDIS_LOCK] = next_module_disable_lock;
        cfg[`CLC_POS_DBG_EN]      = next_debug_port_enable;
        cfg[`CLC_POS_TWO_WIRE]    = next_two_wire_output_use;
        next_hrdata = 32'h0000_0000;
        if (haddr == `CLC_CFG_OFF) begin
            next_hrdata = cfg & `CLC_CFG_MASK;
        end else if (haddr == `CLC_UNLOCK_OFF) begin
            next_hrdata = {31'h0000_0000, next_unlock_state == clc_pkg::clc_unlocked};
        end else if (rd_remap_idx >= 0) begin
            word = remap_regs[rd_remap_idx];
            if (remap_we && wr_remap_idx == rd_remap_idx) begin
                word = hwdata;
            end
            next_hrdata = word;
        end else if (rd_moddis_idx >= 0) begin
            word = moddis_regs[rd_moddis_idx];
            if (moddis_we && wr_moddis_idx == rd_moddis_idx) begin
                word = hwdata;
            end
            next_hrdata = word;
        end
    end

    // read data register, held until the next read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

endmodule

// ### bench/clc_config_lock_assertions.sv
// port checker for the config lock block
// assumes bind onto clc_config_lock, one clock
`timescale 1ns/100ps
`include "clc_regs.svh"
module clc_chk #(
    parameter int NREMAP  = 4,
    parameter int NMODDIS = 2
) (
    // clock, reset
    input wire logic        clk,
    input wire logic        nrst,
    // bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // controls
    input wire logic        debug_port_enable,
    input wire logic        two_wire_output_use,
    input wire logic        pin_remap_lock,
    input wire logic        module_disable_lock,
    input wire logic        unlocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic       tk;
    logic [1:0] wr_q;
    logic       rd_q;
    assign tk = hsel && hready && htrans[1] && hsize == 3'b010;
    // data phase flags: bit1 config write, bit0 unlock write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= 2'b00;
            rd_q <= 1'b0;
        end else begin
            wr_q <= {tk && hwrite && haddr == `CLC_CFG_OFF,
                     tk && hwrite && haddr == `CLC_UNLOCK_OFF};
            rd_q <= tk && !hwrite && haddr == `CLC_CFG_OFF;
        end
    end
    sequence s_key(k);
        wr_q[0] && hwdata == k;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
    a_zero_wait: assert property (hreadyout == 1'b1) else $error("wait state");
    a_remap_guard: assert property ($changed(pin_remap_lock) |-> unlocked || $past(unlocked))
        else $error("remap lock moved while locked");
    a_moddis_guard: assert property ($changed(module_disable_lock) |-> unlocked || $past(unlocked))
        else $error("disable lock moved while locked");
    a_cfg_write: assert property (wr_q[1] |=> {debug_port_enable, two_wire_output_use}
        == {$past(hwdata[3]), $past(hwdata[0])}) else $error("config bits not written");
    a_lock_write: assert property (wr_q[1] |=> (unlocked ?
        {pin_remap_lock, module_disable_lock} == $past(hwdata[13:12])
        : $stable({pin_remap_lock, module_disable_lock}))) else $error("lock write wrong");
    a_cfg_read: assert property (rd_q |-> hrdata == {18'h0, pin_remap_lock,
        module_disable_lock, 8'h0, debug_port_enable, 2'b0, two_wire_output_use}) else $error("cfg read");
    a_unlock_seq: assert property (s_key(`CLC_KEY1) ##3 s_key(`CLC_KEY2) |=> ##[0:1] unlocked)
        else $error("unlock sequence not taken");
endmodule

// ### bench/tb_top.sv
// bench for the config lock block with a register model
// assumes zero wait AHB-Lite slave, single word transfers
`timescale 1ns/100ps
`include "clc_regs.svh"
module tb_top;
    logic        clk = 0, nrst = 0, hsel = 1, hwrite = 0, strap = 0;
    logic [11:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic [31:0] hwdata = 0, hrdata, r;
    logic        hreadyout, hresp, dbg, tw, rlk, mlk, unl;
    int          miscompares = 0, n_tests = 0, st = 0;
    logic [31:0] m [int];
    logic [11:0] adr [7] = '{12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h040};
    always #4 clk = ~clk;
    clc_config_lock dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cfg_debug_port_enable(strap),
        .debug_port_enable(dbg), .two_wire_output_use(tw), .pin_remap_lock(rlk),
        .module_disable_lock(mlk), .unlocked(unl));
    // register model; lock bits only move while unlocked
    function automatic void mw(logic [11:0] a, logic [31:0] d);
        logic [31:0] k;
        k = st == 2 ? `CLC_CFG_MASK : 32'h0000_0009;
        if (a == `CLC_CFG_OFF)
            m[0] = (m[0] & ~k) | (d & k);
        else if (a == `CLC_UNLOCK_OFF && st == 2)
            st = d == 32'h0000_0000 ? 0 : 2;
        else if (a == `CLC_UNLOCK_OFF)
            st = d == `CLC_KEY1 && st == 0 ? 1 : d == `CLC_KEY2 && st == 1 ? 2 : 0;
        else if ((a[11:4] == 8'h01 && !m[0][13]) || (a[11:3] == 9'h004 && !m[0][12]))
            m[a] = d;
    endfunction
    function automatic logic [31:0] mr(logic [11:0] a);
        if (a == `CLC_UNLOCK_OFF)
            return {31'h0, st == 2};
        return m.exists(a) ? m[a] : 32'h0;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one transfer; an idle cycle first keeps phases apart
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        if (w)
            mw(a, d);
    endtask
    task automatic rdc(logic [11:0] a);
        xfer(0, a, 0);
        chk("register", r, mr(a));
    endtask
    task automatic unlock();
        xfer(1, `CLC_UNLOCK_OFF, `CLC_KEY1);
        xfer(1, `CLC_UNLOCK_OFF, `CLC_KEY2);
    endtask
    // random bank writes, then read back everything
    task automatic sweep();
        foreach (adr[i]) xfer(1, adr[i], $urandom);
        foreach (adr[i]) rdc(adr[i]);
        rdc(`CLC_CFG_OFF);
        rdc(`CLC_UNLOCK_OFF);
        chk("pins", {dbg, tw, rlk, mlk, unl}, {m[0][3], m[0][0], m[0][13:12], st == 2});
    endtask
    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles needed
    initial begin
        #40000;
        miscompares++;
        stop_test();
    end
    initial begin
        r = $urandom(32'h4aee_96a7);
        strap = $urandom;
        m[0] = {28'h0, strap, 3'b001};
        repeat (6) @(posedge clk);
        nrst <= 1;
        repeat (2) @(posedge clk);
        sweep();
        xfer(1, `CLC_CFG_OFF, 32'hffff_ffff);
        sweep();
        unlock();
        xfer(1, `CLC_UNLOCK_OFF, `CLC_KEY1);
        xfer(1, `CLC_CFG_OFF, 32'hffff_ffff);
        sweep();
        xfer(1, `CLC_UNLOCK_OFF, 32'h0000_0000);
        xfer(1, `CLC_CFG_OFF, 32'h0000_0000);
        sweep();
        xfer(1, `CLC_UNLOCK_OFF, `CLC_KEY1);
        xfer(1, `CLC_UNLOCK_OFF, 32'h1234_5678);
        xfer(1, `CLC_UNLOCK_OFF, `CLC_KEY2);
        xfer(1, `CLC_CFG_OFF, 32'h0000_0008);
        sweep();
        unlock();
        xfer(1, `CLC_CFG_OFF, 32'h0000_2001);
        sweep();
        // second reset with the configuration bit flipped
        nrst  <= 0;
        strap <= ~strap;
        repeat (6) @(posedge clk);
        m.delete();
        m[0] = {28'h0, strap, 3'b001};
        st = 0;
        nrst <= 1;
        repeat (2) @(posedge clk);
        sweep();
        stop_test();
    end
endmodule
bind clc_config_lock clc_chk #(.NREMAP(NREMAP), .NMODDIS(NMODDIS)) chk_u (.clk, .nrst, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .debug_port_enable, .two_wire_output_use, .pin_remap_lock, .module_disable_lock, .unlocked);
